// file: logic/rrc_pkg.sv
package rrc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ         = 25_000_000;  // MCLK rate
  localparam int unsigned REF_SETTLE_US  = 25;          // Reference settling time, us
  // Least time, so the count rounds up to whole cycles
  localparam int unsigned REF_SETTLE_CYC =
    (REF_SETTLE_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned SETTLE_CNT_W   = 10;          // Holds REF_SETTLE_CYC

  // ****************************************************************
  // Register map (byte addresses on APB)
  // ****************************************************************
  localparam logic [7:0] REFCTL_OFS  = 8'h00;  // reference_control
  localparam logic [7:0] REGCTL_OFS  = 8'h04;  // regulator_control
  localparam logic [7:0] IRQSTS_OFS  = 8'h08;  // Sticky event status, write one to clear
  localparam logic [7:0] IRQMSK_OFS  = 8'h0c;  // Event mask, one passes the event
  localparam logic [7:0] MODESTS_OFS = 8'h10;  // Live regulator mode, read only

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned REF_EN_BIT  = 7;     // Reference enable
  localparam int unsigned REF_RDY_BIT = 6;     // Ready flag, read only
  localparam int unsigned TEMP_EN_BIT = 5;     // Temperature indicator enable
  localparam int unsigned TEMP_RG_BIT = 4;     // Temperature range select
  localparam int unsigned SLP_SEL_BIT = 1;     // Sleep regulator mode select
  localparam logic [7:0]  REFCTL_RST  = 8'h00;
  localparam logic [7:0]  REGCTL_RST  = 8'h01; // Keep-one bit comes up set
  localparam logic [7:0]  REFCTL_WMSK = 8'hb3; // Writable bits of reference_control
  localparam logic [7:0]  REGCTL_WMSK = 8'h03; // Writable bits of regulator_control

  // Events
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_RDY_BIT  = 0;    // Reference became ready
  localparam int unsigned IRQ_MODE_BIT = 1;    // Regulator mode changed
  localparam logic [1:0]  IRQ_RST      = 2'h0;

  // Clock setting codes: 0..2 are 31 kHz..500 kHz, 3..7 are 1 MHz..16 MHz
  localparam logic [2:0]  OSC_HIGH_MIN = 3'h3;
  // Converter channel code reserved for the temperature indicator
  localparam logic [2:0]  TEMP_CHANNEL = 3'h6;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    RRC_PM_SAVE = 2'b00,   // Power-save sleep regulator
    RRC_PM_LOW  = 2'b01,   // Low power regulator
    RRC_PM_HIGH = 2'b10    // High power regulator
  } rrc_pmode_t;
  localparam rrc_pmode_t PMODE_RST = RRC_PM_HIGH;

  // reference_control layout
  typedef struct packed {
    logic       enable;
    logic       ready;
    logic       temp_en;
    logic       temp_rng;
    logic [1:0] unused;
    logic [1:0] gain;
  } rrc_refctl_t;

  // Conditions that keep the regulator out of power-save sleep
  typedef struct packed {
    logic brownout_en;
    logic hfosc_act;
    logic self_write;
    logic conv_act;
  } rrc_force_t;

endpackage

// file: logic/rrc_settle.sv
`timescale 1ns/1ps
module rrc_settle
  import rrc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic enable,
  output logic      ready
);
  // ****************************************************************
  // Settling counter
  // ****************************************************************
  localparam logic [SETTLE_CNT_W-1:0] LAST = SETTLE_CNT_W'(REF_SETTLE_CYC);

  logic [SETTLE_CNT_W-1:0] cnt_q;   // Cycles since enable rose
  logic [SETTLE_CNT_W-1:0] cnt_d;
  logic                    ready_q;
  logic                    ready_d;

  // Restart from zero whenever the reference is off
  assign cnt_d   = !enable ? '0 : (cnt_q == LAST) ? cnt_q : cnt_q + 1'b1;
  assign ready_d = enable && (cnt_d == LAST);
  assign ready   = ready_q;

  // Counter and flag registers
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q   <= '0;
      ready_q <= 1'b0;
    end else if (ce) begin
      cnt_q   <= cnt_d;
      ready_q <= ready_d;
    end
  end

  settle_time_a : assert property (@(posedge clk) disable iff (rst)
    ready_q |-> cnt_q == LAST)
    else $error("ready set before settling count expired");

  settle_drop_a : assert property (@(posedge clk) disable iff (rst)
    (ce && !enable) |=> !ready_q && cnt_q == '0)
    else $error("ready or count survived disable");

endmodule

// file: logic/rrc_pmode.sv
`timescale 1ns/1ps
module rrc_pmode
  import rrc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       sleep,
  input  wire logic       save_sel,
  input  wire logic       ec_mode,
  input  wire logic [2:0] osc_sel,
  input  rrc_force_t      force_low,
  output rrc_pmode_t      mode
);
  // ****************************************************************
  // Regulator power mode selection
  // ****************************************************************
  rrc_pmode_t mode_q;
  rrc_pmode_t mode_d;
  logic       fast_clk;
  logic       any_force;

  assign fast_clk  = ec_mode || (osc_sel >= OSC_HIGH_MIN);
  assign any_force = |force_low;
  // Awake: by clock; asleep: by select, overruled by any active user
  assign mode_d = !sleep ? (fast_clk ? RRC_PM_HIGH : RRC_PM_LOW) :
                  (save_sel && !any_force) ? RRC_PM_SAVE : RRC_PM_LOW;
  assign mode   = mode_q;

  // Mode register, so the output is glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= PMODE_RST;
    end else if (ce) begin
      mode_q <= mode_d;
    end
  end

  pmode_awake_a : assert property (@(posedge clk) disable iff (rst)
    (ce && !sleep) |=> mode_q == ($past(fast_clk) ? RRC_PM_HIGH : RRC_PM_LOW))
    else $error("awake regulator mode wrong");

  pmode_sleep_a : assert property (@(posedge clk) disable iff (rst)
    (ce && sleep && !save_sel) |=> mode_q == RRC_PM_LOW)
    else $error("low power sleep not selected");

  pmode_force_a : assert property (@(posedge clk) disable iff (rst)
    (ce && sleep && save_sel) |=> (mode_q == RRC_PM_SAVE) == !$past(any_force))
    else $error("power-save sleep forcing wrong");

endmodule

// file: logic/rrc_top.sv
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module rrc_top
  import rrc_pkg::*;
(
  input  wire logic             MCLK,
  input  wire logic             SYS_RST,
  input  wire logic             CLK_EN,
  // APB slave
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [7:0]       PADDR,
  input  wire logic [31:0]      PWDATA,
  input  wire logic [3:0]       PSTRB,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  output logic                  IRQ,
  // Device state, all from logic on MCLK
  input  wire logic             SLEEP,
  input  wire logic             EC_MODE,
  input  wire logic [2:0]       OSC_SEL,
  input  rrc_pkg::rrc_force_t   FORCE_LOW,
  input  wire logic [2:0]       CONV_CHANNEL,
  // Analog controls
  output logic                  REF_ENABLE,
  output logic                  REF_READY,
  output logic                  TEMP_EN,
  output logic                  TEMP_RANGE,
  output logic [1:0]            REF_GAIN,
  output logic                  TEMP_ROUTE,
  output rrc_pkg::rrc_pmode_t   REG_MODE
);
  import rrc_pkg::*;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        setup;       // First cycle of a transfer
  logic        wr_acc;      // Write takes effect at this edge
  logic        wr_lane;     // Low byte lane enabled
  logic        hit_ref;
  logic        hit_reg;
  logic        hit_sts;
  logic        hit_msk;
  logic        hit_mode;
  logic        hit_any;
  logic        pready_q;    // Registered answer, high for one access cycle

  // CLK_EN must stay high across a transfer: a frozen access edge would
  // still show PREADY to the master while the write is held back
  assign setup    = PSEL && !PENABLE;
  assign wr_acc   = PSEL && PENABLE && PWRITE && pready_q;
  assign wr_lane  = PSTRB[0];
  assign hit_ref  = PADDR == REFCTL_OFS;
  assign hit_reg  = PADDR == REGCTL_OFS;
  assign hit_sts  = PADDR == IRQSTS_OFS;
  assign hit_msk  = PADDR == IRQMSK_OFS;
  assign hit_mode = PADDR == MODESTS_OFS;
  assign hit_any  = hit_ref || hit_reg || hit_sts || hit_msk || hit_mode;

  // ****************************************************************
  // Registers
  // ****************************************************************
  rrc_refctl_t            ref_q;      // Stored control fields
  rrc_refctl_t            ref_d;
  logic [7:0]             regc_q;     // regulator_control
  logic [7:0]             regc_d;
  logic [IRQ_W-1:0]       sts_q;      // Sticky events
  logic [IRQ_W-1:0]       sts_d;
  logic [IRQ_W-1:0]       msk_q;      // Event mask
  logic [IRQ_W-1:0]       msk_d;
  logic [IRQ_W-1:0]       evt;        // Events this cycle
  logic [IRQ_W-1:0]       clr;        // Write-one-to-clear bits
  logic [31:0]            prdata_q;
  logic [31:0]            rdata;
  logic                   pslverr_q;
  logic                   irq_q;
  logic                   route_q;
  logic                   ready_prev_q;
  rrc_pmode_t             mode_prev_q;
  logic                   ref_ready;  // Settled flag from the counter
  rrc_pmode_t             mode;       // Current regulator mode
  rrc_refctl_t            ref_view;   // Read view of reference_control

  // Control writes keep only implemented bits
  assign ref_d  = (wr_acc && wr_lane && hit_ref) ?
                  rrc_refctl_t'(PWDATA[7:0] & REFCTL_WMSK) : ref_q;
  assign regc_d = (wr_acc && wr_lane && hit_reg) ?
                  (PWDATA[7:0] & REGCTL_WMSK) : regc_q;
  assign msk_d  = (wr_acc && wr_lane && hit_msk) ? PWDATA[IRQ_W-1:0] : msk_q;

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  // A new event wins over a clear landing in the same cycle
  assign evt[IRQ_RDY_BIT]  = ref_ready && !ready_prev_q;
  assign evt[IRQ_MODE_BIT] = mode != mode_prev_q;
  assign clr   = (wr_acc && wr_lane && hit_sts) ? PWDATA[IRQ_W-1:0] : '0;
  assign sts_d = (sts_q & ~clr) | evt;

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Ready is live state; unused bits are forced to zero
  // Gated by the enable, since the counter flag drops one edge late
  always_comb begin
    ref_view        = ref_q;
    ref_view.ready  = ref_ready && ref_q.enable;
    ref_view.unused = 2'b00;
  end

  assign rdata = hit_ref  ? {24'h000000, ref_view}         :
                 hit_reg  ? {24'h000000, regc_q}           :
                 hit_sts  ? {30'h0, sts_q}                 :
                 hit_msk  ? {30'h0, msk_q}                 :
                 hit_mode ? {30'h0, mode}                  : 32'h00000000;

  // ****************************************************************
  // Bus answer registers
  // ****************************************************************
  // Answer is prepared in the setup cycle, so every access has no wait
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (CLK_EN) begin
      pready_q  <= setup;
      prdata_q  <= (setup && !PWRITE) ? rdata : 32'h00000000;
      pslverr_q <= setup && !hit_any;
    end
  end

  // ****************************************************************
  // Control and status registers
  // ****************************************************************
  // Reset values; regulator keep-one bit comes up set
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ref_q  <= rrc_refctl_t'(REFCTL_RST);
      regc_q <= REGCTL_RST;
      sts_q  <= IRQ_RST;
      msk_q  <= IRQ_RST;
    end else if (CLK_EN) begin
      ref_q  <= ref_d;
      regc_q <= regc_d;
      sts_q  <= sts_d;
      msk_q  <= msk_d;
    end
  end

  // ****************************************************************
  // Output and history registers
  // ****************************************************************
  // Route only when the indicator is on and its channel is selected
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      irq_q        <= 1'b0;
      route_q      <= 1'b0;
      ready_prev_q <= 1'b0;
      mode_prev_q  <= PMODE_RST;
    end else if (CLK_EN) begin
      irq_q        <= |(sts_d & msk_d);
      route_q      <= ref_d.temp_en && (CONV_CHANNEL == TEMP_CHANNEL);
      ready_prev_q <= ref_ready;
      mode_prev_q  <= mode;
    end
  end

  // ****************************************************************
  // Submodules
  // ****************************************************************
  // Ready follows the enable through the settling counter
  rrc_settle u_settle (
    .clk    (MCLK),
    .rst    (SYS_RST),
    .ce     (CLK_EN),
    .enable (ref_q.enable),
    .ready  (ref_ready)
  );

  // Regulator mode from sleep, clock setting and active users
  rrc_pmode u_pmode (
    .clk       (MCLK),
    .rst       (SYS_RST),
    .ce        (CLK_EN),
    .sleep     (SLEEP),
    .save_sel  (regc_q[SLP_SEL_BIT]),
    .ec_mode   (EC_MODE),
    .osc_sel   (OSC_SEL),
    .force_low (FORCE_LOW),
    .mode      (mode)
  );

  // ****************************************************************
  // Outputs, each straight from a register
  // ****************************************************************
  assign PREADY     = pready_q;
  assign PRDATA     = prdata_q;
  assign PSLVERR    = pslverr_q;
  assign IRQ        = irq_q;
  assign REF_ENABLE = ref_q.enable;
  assign REF_READY  = ref_ready;
  assign TEMP_EN    = ref_q.temp_en;
  assign TEMP_RANGE = ref_q.temp_rng;
  assign REF_GAIN   = ref_q.gain;
  assign TEMP_ROUTE = route_q;
  assign REG_MODE   = mode;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  sequence ref_write_s;
    CLK_EN && wr_acc && wr_lane && hit_ref;
  endsequence

  sequence ref_read_s;
    CLK_EN && setup && !PWRITE && hit_ref;
  endsequence

  ref_enable_a : assert property (ref_write_s |=> REF_ENABLE == $past(PWDATA[7]))
    else $error("reference enable not taken from write");

  ready_off_a : assert property (
    (!REF_ENABLE && $past(!REF_ENABLE) && $past(CLK_EN)) |-> !REF_READY)
    else $error("ready shown while reference disabled");

  ready_read_a : assert property (
    ref_read_s |=> PRDATA[REF_RDY_BIT] == $past(ref_ready && ref_q.enable) && PREADY)
    else $error("ready bit read back wrong");

  temp_en_a : assert property (ref_write_s |=> TEMP_EN == $past(PWDATA[5]))
    else $error("temperature enable not taken");

  temp_range_a : assert property (ref_write_s |=> TEMP_RANGE == $past(PWDATA[4]))
    else $error("temperature range not taken");

  gain_sel_a : assert property (ref_write_s |=> REF_GAIN == $past(PWDATA[1:0]))
    else $error("gain field not taken");

  unimpl_zero_a : assert property (
    ref_read_s |=> PRDATA[3:2] == 2'b00 && PRDATA[31:8] == 24'h000000)
    else $error("unimplemented bits read nonzero");

  temp_route_a : assert property (
    (CLK_EN && TEMP_EN && CONV_CHANNEL == TEMP_CHANNEL && !wr_acc) |=> TEMP_ROUTE)
    else $error("indicator not routed to its channel");

  settle_wait_a : assert property (
    (CLK_EN && $rose(REF_ENABLE)) |-> !REF_READY [*8])
    else $error("ready rose too soon after enable");

  irq_level_a : assert property (
    (CLK_EN && |(sts_q & msk_q) && !wr_acc) |=> IRQ)
    else $error("interrupt low with unmasked event pending");

  // ****************************************************************
  // Bus and event checks
  // ****************************************************************
  // A setup cycle seen on an enabled edge
  sequence bus_setup_s;
    CLK_EN && setup;
  endsequence

  // A read of the live regulator mode
  sequence mode_read_s;
    CLK_EN && setup && !PWRITE && hit_mode;
  endsequence

  // Every setup is answered in the very next cycle
  pready_next_a : assert property (bus_setup_s |=> PREADY)
    else $error("no answer after setup");

  // The answer stands for one cycle only
  pready_once_a : assert property ((CLK_EN && PREADY) |=> !PREADY)
    else $error("answer held past its access cycle");

  // Unmapped offsets answer with an error and zero data
  slverr_map_a : assert property (
    (CLK_EN && setup && !hit_any) |=> PSLVERR && PREADY && PRDATA == 32'h00000000)
    else $error("unmapped access not flagged");

  // Mapped offsets never flag an error
  slverr_none_a : assert property ((CLK_EN && setup && hit_any) |=> !PSLVERR)
    else $error("mapped access flagged as error");

  // A write with the low lane off leaves both control registers alone
  strobe_skip_a : assert property (
    (CLK_EN && wr_acc && !wr_lane) |=> $stable(ref_q) && $stable(regc_q))
    else $error("write with low lane disabled took effect");

  // Stored regulator bits are the written ones; the rest stay zero
  regctl_write_a : assert property (
    (CLK_EN && wr_acc && wr_lane && hit_reg) |=>
      regc_q == ($past(PWDATA[7:0]) & REGCTL_WMSK))
    else $error("regulator control write wrong");

  // An event sets its status bit even against a clear in the same cycle
  evt_sticky_a : assert property (
    (CLK_EN && |evt) |=> (sts_q & $past(evt)) == $past(evt))
    else $error("event lost against a clear");

  // A disabled reference never reads back as ready
  ready_gate_a : assert property (
    (CLK_EN && setup && !PWRITE && hit_ref && !REF_ENABLE) |=> !PRDATA[REF_RDY_BIT])
    else $error("ready read while reference disabled");

  // Route drops once the converter looks at another channel
  route_off_a : assert property (
    (CLK_EN && CONV_CHANNEL != TEMP_CHANNEL) |=> !TEMP_ROUTE)
    else $error("indicator routed to a foreign channel");

  // Mode status read returns the live regulator mode
  mode_read_a : assert property (
    mode_read_s |=> PRDATA[1:0] == $past(mode) && PRDATA[31:2] == 30'h0)
    else $error("mode status read back wrong");

endmodule

// file: verification/rrc_analog_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Analog side: reference buffer, temperature string, converter tap
// ****************************************************************
module rrc_analog_model (
  input  wire logic        clk,
  input  wire logic        ref_enable,
  input  wire logic        ref_ready,
  input  wire logic [1:0]  gain,
  input  wire logic        temp_en,
  input  wire logic        temp_range,
  input  wire logic        temp_route,
  output logic      [12:0] ref_mv,
  output logic      [2:0]  temp_drops,
  output logic             temp_on_adc
);
  logic [12:0] junk_q = 13'h0aa5;  // Unsettled output, wanders each cycle

  // An unsettled buffer is never a stable value a reader could trust
  always_ff @(posedge clk) begin
    junk_q <= ~junk_q + 13'h0155;
  end

  // Off, or 1x/2x/4x of the base step once settled
  assign ref_mv = (!ref_enable || gain == 2'h0) ? 13'h0000 :
                  (!ref_ready ? junk_q : (13'h0400 << (gain - 2'h1)));
  // Four junctions in high range, two in low, none when off
  assign temp_drops = !temp_en ? 3'h0 : (temp_range ? 3'h4 : 3'h2);
  assign temp_on_adc = temp_route;
endmodule

// file: verification/tb_reference_regulator_control.sv
`timescale 1ns/1ps
module tb_reference_regulator_control;
  import rrc_pkg::*;
  localparam int TS_WAIT = 5000;  // 200 us of settle time at 25 MHz
  logic        MCLK, SYS_RST, CLK_EN, PSEL, PENABLE, PWRITE, SLEEP, EC_MODE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [3:0]  PSTRB;
  logic        PREADY, PSLVERR, IRQ, REF_ENABLE, REF_READY, TEMP_EN, TEMP_RANGE, TEMP_ROUTE;
  logic [2:0]  OSC_SEL, CONV_CHANNEL, drops;
  logic [1:0]  REF_GAIN;
  logic [12:0] ref_mv;
  rrc_force_t  FORCE_LOW;
  rrc_pmode_t  REG_MODE;
  int          err_count, n_checks, n, em, prev, s, ec, osc, sel, f;
  logic [31:0] d, r;
  logic        e;

  rrc_top u_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .SLEEP(SLEEP),
    .EC_MODE(EC_MODE), .OSC_SEL(OSC_SEL), .FORCE_LOW(FORCE_LOW),
    .CONV_CHANNEL(CONV_CHANNEL), .REF_ENABLE(REF_ENABLE), .REF_READY(REF_READY),
    .TEMP_EN(TEMP_EN), .TEMP_RANGE(TEMP_RANGE), .REF_GAIN(REF_GAIN),
    .TEMP_ROUTE(TEMP_ROUTE), .REG_MODE(REG_MODE));
  rrc_analog_model u_ana (.clk(MCLK), .ref_enable(REF_ENABLE), .ref_ready(REF_READY),
    .gain(REF_GAIN), .temp_en(TEMP_EN), .temp_range(TEMP_RANGE),
    .temp_route(TEMP_ROUTE), .ref_mv(ref_mv), .temp_drops(drops), .temp_on_adc());

  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      err_count++;
      $display("FAIL %s exp %h got %h", nm, x, g);
    end
  endtask

  // One APB transfer; request held until PREADY is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int k;
    k = 0;
    @(posedge MCLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    // Sampled at the rising edge itself, before the design moves on
    do begin
      @(posedge MCLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_count++;
      test_done();
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] t;
    logic        x;
    apb(1'b1, a, v, t, x);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] t;
    logic        q;
    apb(1'b0, a, 32'h0, t, q);
    chk(nm, x, t);
  endtask

  // Let n edges land, then look mid-cycle
  task automatic settle(input int c);
    repeat (c) @(posedge MCLK);
    @(negedge MCLK);
  endtask

  // Expected regulator mode: 0 save, 1 low, 2 high
  function automatic int exp_mode(int sl, int ecm, int oc, int sv, int fl);
    if (sl == 0) return (ecm != 0 || oc >= 3) ? 2 : 1;
    if (sv == 0 || fl != 0) return 1;
    return 0;
  endfunction

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    {PSEL, PENABLE, PWRITE, SLEEP, EC_MODE} = 5'h00;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    PSTRB = 4'hf;
    CLK_EN = 1'b1;
    SYS_RST = 1'b1;
    OSC_SEL = 3'h7;
    FORCE_LOW = '0;
    CONV_CHANNEL = 3'h0;
    err_count = 0;
    n_checks = 0;
    n = $urandom(41662);
    repeat (12) @(posedge MCLK);
    SYS_RST <= 1'b0;
    rdc("refctl", REFCTL_OFS, 32'h0);
    rdc("regctl", REGCTL_OFS, 32'h1);
    rdc("mode", MODESTS_OFS, 32'h2);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk("unmapped", 32'h1, {31'h0, e});
    // A write with the low byte lane off must be dropped
    PSTRB <= 4'he;
    wr(REFCTL_OFS, 32'h000000b3);
    PSTRB <= 4'hf;
    rdc("strobe_off", REFCTL_OFS, 32'h0);
    $display("test reset done");
    // Every gain code, random temperature bits, read-only bits poked
    for (int g = 0; g < 4; g++) begin
      d = ($urandom & 32'hffffff7c) | g;
      wr(REFCTL_OFS, d);
      settle(0);
      chk("temp_en", d[5], TEMP_EN);
      chk("temp_rng", d[4], TEMP_RANGE);
      chk("drops", d[5] ? (d[4] ? 4 : 2) : 0, drops);
      chk("gain", g, REF_GAIN);
      chk("ref_off", 0, ref_mv);
      rdc("refctl", REFCTL_OFS, d & 32'h33);
    end
    $display("test fields done");
    // Enable at 4x, time the settle, then walk the interrupt
    wr(IRQSTS_OFS, 32'h3);
    wr(IRQMSK_OFS, 32'h1);
    wr(REFCTL_OFS, 32'h83);
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
      @(negedge MCLK);
    end while (REF_READY !== 1'b1 && n < 2000);
    chk("settle", REF_SETTLE_CYC, n);
    if (n >= 2000) test_done();
    chk("ref_en", 1, REF_ENABLE);
    chk("ref_mv", 4096, ref_mv);
    rdc("refctl", REFCTL_OFS, 32'hc3);
    settle(2);
    chk("irq", 1, IRQ);
    rdc("sts", IRQSTS_OFS, 32'h1);
    wr(IRQMSK_OFS, 32'h0);
    settle(2);
    chk("irq_mask", 0, IRQ);
    wr(IRQMSK_OFS, 32'h1);
    settle(2);
    chk("irq_unmask", 1, IRQ);
    wr(IRQSTS_OFS, 32'h1);
    settle(2);
    chk("irq_clr", 0, IRQ);
    wr(REFCTL_OFS, 32'h03);
    settle(1);
    chk("ready_off", 0, REF_READY);
    rdc("refctl", REFCTL_OFS, 32'h03);
    $display("test ready done");
    // Random device states against the mode table
    prev = exp_mode(0, 0, 7, 0, 0);
    for (int i = 0; i < 40; i++) begin
      s = $urandom % 2;
      ec = $urandom % 2;
      osc = $urandom % 8;
      sel = $urandom % 2;
      f = ($urandom % 3 == 0) ? (1 << ($urandom % 4)) : 0;
      wr(REGCTL_OFS, (sel << 1) | 1);
      SLEEP <= s[0];
      EC_MODE <= ec[0];
      OSC_SEL <= osc[2:0];
      FORCE_LOW <= rrc_force_t'(f[3:0]);
      settle(2);
      em = exp_mode(s, ec, osc, sel, f);
      chk("reg_mode", em, {30'h0, REG_MODE});
      rdc("mode_sts", MODESTS_OFS, em);
      rdc("regctl", REGCTL_OFS, (sel << 1) | 1);
      apb(1'b0, IRQSTS_OFS, 32'h0, r, e);
      if (em != prev) chk("mode_evt", 32'h2, r & 32'h2);
      wr(IRQSTS_OFS, 32'h2);
      prev = em;
    end
    $display("test mode done");
    // Indicator to its channel; conversions spaced by the settle time
    wr(REFCTL_OFS, 32'h20);
    wr(REGCTL_OFS, 32'h3);
    SLEEP <= 1'b1;
    FORCE_LOW <= '0;
    CONV_CHANNEL <= TEMP_CHANNEL;
    settle(2);
    chk("route", 1, TEMP_ROUTE);
    chk("save", 0, {30'h0, REG_MODE});
    for (int c = 0; c < 2; c++) begin
      repeat (TS_WAIT) @(posedge MCLK);
      FORCE_LOW.conv_act <= 1'b1;
      settle(2);
      chk("conv_low", 1, {30'h0, REG_MODE});
      @(posedge MCLK);
      FORCE_LOW.conv_act <= 1'b0;
      settle(2);
      chk("conv_save", 0, {30'h0, REG_MODE});
    end
    @(posedge MCLK);
    CONV_CHANNEL <= 3'h5;
    settle(2);
    chk("route_off", 0, TEMP_ROUTE);
    $display("test route done");
    test_done();
  end
endmodule
